/* hw/sleep_clock_ctrl.sv */
// Purpose: Sleep mode sequencer and clock domain gating controller
// Assumes: Wake inputs are already qualified by their interrupt enables
// Notes:   All gating is by one-cycle-resolved enables on i_mclk
//
// Operation
// - Idle stops core and flash clocks only
// - Idle wakes on external or peripheral interrupts
// - Idle or noise entry starts enabled conversion
// - Noise mode stops I/O, core, flash clocks
// - Noise mode wakes on listed events
// - Power-down stops oscillator and all clocks
// - Power-down and standby wake on listed events
// - Standby keeps oscillator; wakes in six cycles
// - Clock-stop bit freezes peripheral, blocks access
// - Clearing stop bit resumes peripheral unchanged
// - Converter stays enabled; re-enable means extended
// - Deep modes disable the comparator automatically
// - Comparator on reference keeps reference enabled
// - Reference enabled when some user needs, or comparator on
// - Fused brown-out stays on; sampled option
// - Enabled watchdog runs in every sleep mode
// - Deep modes disable input buffers except wake
// - Debug fuse keeps main clock always running
// - Mode codes: idle, noise, power-down, standby
// - Sleep instruction acts only with enable set
// - Wake holds core four cycles after start-up
`timescale 1ns/1ps
`include "sleep_ctrl_defines.svh"

module sleep_clock_ctrl #(
    parameter int               PIN_W          = 18,
    parameter logic [`CNT_W-1:0] OSC_STARTUP    = `OSC_STARTUP_DEFAULT
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_sys_rst,
    // Core request and sleep configuration
    input  wire logic                 i_sleep_instr,
    input  wire logic                 i_sleep_enable_bit,
    input  wire logic [1:0]           i_sleep_mode_select,
    input  wire logic [`PERIPH_W-1:0] i_peripheral_clock_stop_bits,
    // Analog and fuse configuration
    input  wire logic                 i_converter_enable,
    input  wire logic                 i_comparator_disable,
    input  wire logic                 i_comparator_uses_ref,
    input  wire logic                 i_brownout_sleep_fuse,
    input  wire logic                 i_brownout_sampled_sel,
    input  wire logic                 i_watchdog_enable,
    input  wire logic                 i_debug_link_enable_fuse,
    input  wire logic [PIN_W-1:0]     i_digital_input_disable_bits,
    input  wire logic [PIN_W-1:0]     i_wake_pin_mask,
    // Asynchronous wake sources
    input  wire logic                 i_external_level_interrupt,
    input  wire logic                 i_pin_change_irq,
    input  wire logic                 i_universal_serial_unit_start,
    input  wire logic                 i_start_frame_detect,
    input  wire logic                 i_two_wire_slave_match,
    input  wire logic                 i_watchdog_irq,
    // Same-clock wake sources
    input  wire logic                 i_periph_irq,
    input  wire logic                 i_conv_done,
    input  wire logic                 i_self_program_write_ready,
    // Clock domain enables
    output logic                      o_core_clk_en,
    output logic                      o_flash_clk_en,
    output logic                      o_io_clk_en,
    output logic                      o_conv_clk_en,
    output logic                      o_osc_enable,
    output logic [`PERIPH_W-1:0]      o_periph_clk_en,
    output logic [`PERIPH_W-1:0]      o_periph_access_block,
    // Core handshake
    output logic                      o_sleeping,
    output logic                      o_core_hold,
    output logic                      o_resume,
    // Analog, fuse and pin controls
    output logic                      o_conv_start,
    output logic                      o_conv_extended,
    output logic                      o_converter_power,
    output logic                      o_comparator_power,
    output logic                      o_reference_enable,
    output logic                      o_brownout_active,
    output logic                      o_brownout_sampled,
    output logic                      o_watchdog_run,
    output logic [PIN_W-1:0]          o_input_buffer_en
);

    // ======================================================================
    // Wake input synchronisers
    // ======================================================================
    localparam int ASYNC_W = 6;

    logic [ASYNC_W-1:0] wake_async;
    logic [ASYNC_W-1:0] wake_sync;
    logic               w_level;
    logic               w_pinchg;
    logic               w_serial;
    logic               w_frame;
    logic               w_twi;
    logic               w_wdog;

    // Pins and the watchdog oscillator lie outside i_mclk
    assign wake_async = {i_external_level_interrupt, i_pin_change_irq,
                         i_universal_serial_unit_start,
                         i_start_frame_detect, i_two_wire_slave_match,
                         i_watchdog_irq};

    sync2 #(
        .W (ASYNC_W)
    ) u_wake_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_async   (wake_async),
        .o_sync    (wake_sync)
    );

    assign {w_level, w_pinchg, w_serial, w_frame, w_twi, w_wdog} = wake_sync;

    // ======================================================================
    // Sleep sequencer
    // ======================================================================
    sleep_ctrl_pkg::pm_state_t   state;
    sleep_ctrl_pkg::pm_state_t   next_state;
    sleep_ctrl_pkg::sleep_mode_t mode;
    sleep_ctrl_pkg::sleep_mode_t next_mode;
    logic [`CNT_W-1:0]           cnt;
    logic [`CNT_W-1:0]           next_cnt;
    logic                        conv_start;
    logic                        next_conv_start;
    logic                        resume;
    logic                        next_resume;
    logic                        deep_wake;
    logic                        wake;
    logic                        osc_kept;

    // Deep-mode sources: level, pin change, serial start, frame, match, watchdog
    assign deep_wake = w_level | w_pinchg | w_serial | w_frame | w_twi
                     | w_wdog;
    assign osc_kept  = i_debug_link_enable_fuse;

    // Wake set chosen by the mode latched at entry
    always_comb begin
        case (mode)
            sleep_ctrl_pkg::MODE_IDLE:
                wake = deep_wake | i_periph_irq | i_conv_done
                     | i_self_program_write_ready;
            sleep_ctrl_pkg::MODE_NOISE:
                wake = deep_wake | i_conv_done
                     | i_self_program_write_ready;
            default:
                wake = deep_wake;
        endcase
    end

    // Next state, counter, entry and resume pulses
    always_comb begin
        next_state      = state;
        next_mode       = mode;
        next_cnt        = cnt;
        next_conv_start = 1'b0;
        next_resume     = 1'b0;
        case (state)
            sleep_ctrl_pkg::ST_ACTIVE: begin
                if (i_sleep_instr && i_sleep_enable_bit) begin
                    next_state = sleep_ctrl_pkg::ST_SLEEP;
                    next_mode  = sleep_ctrl_pkg::sleep_mode_t'(
                                     i_sleep_mode_select);
                    if (i_converter_enable
                        && !i_sleep_mode_select[1]) begin
                        next_conv_start = 1'b1;
                    end
                end
            end
            sleep_ctrl_pkg::ST_SLEEP: begin
                if (wake) begin
                    case (mode)
                        sleep_ctrl_pkg::MODE_PWR_DOWN: begin
                            next_state = sleep_ctrl_pkg::ST_STARTUP;
                            next_cnt   = osc_kept ? `STANDBY_WAKE_CYCLES
                                                  : OSC_STARTUP;
                        end
                        sleep_ctrl_pkg::MODE_STANDBY: begin
                            next_state = sleep_ctrl_pkg::ST_STARTUP;
                            next_cnt   = `STANDBY_WAKE_CYCLES;
                        end
                        default: begin
                            next_state = sleep_ctrl_pkg::ST_HOLD;
                            next_cnt   = `WAKE_HOLD_CYCLES;
                        end
                    endcase
                end
            end
            sleep_ctrl_pkg::ST_STARTUP: begin
                if (cnt <= `CNT_ONE) begin
                    next_state = sleep_ctrl_pkg::ST_HOLD;
                    next_cnt   = `WAKE_HOLD_CYCLES;
                end else begin
                    next_cnt = cnt - `CNT_ONE;
                end
            end
            sleep_ctrl_pkg::ST_HOLD: begin
                if (cnt <= `CNT_ONE) begin
                    next_state  = sleep_ctrl_pkg::ST_ACTIVE;
                    next_cnt    = `CNT_ZERO;
                    next_resume = 1'b1;
                end else begin
                    next_cnt = cnt - `CNT_ONE;
                end
            end
            default: begin
                next_state = sleep_ctrl_pkg::ST_ACTIVE;
                next_cnt   = `CNT_ZERO;
            end
        endcase
    end

    // Asynchronous reset always lands in active mode
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state      <= sleep_ctrl_pkg::ST_ACTIVE;
            mode       <= sleep_ctrl_pkg::MODE_IDLE;
            cnt        <= `CNT_ZERO;
            conv_start <= 1'b0;
            resume     <= 1'b0;
        end else begin
            state      <= next_state;
            mode       <= next_mode;
            cnt        <= next_cnt;
            conv_start <= next_conv_start;
            resume     <= next_resume;
        end
    end

    // ======================================================================
    // Clock domain requests
    // ======================================================================
    logic                 in_sleep;
    logic                 deep;
    logic                 req_core;
    logic                 req_io;
    logic                 req_conv;
    logic                 req_osc;
    logic [`PERIPH_W-1:0] periph_base;
    logic [`PERIPH_W-1:0] req_periph;
    logic [`PERIPH_W+4:0] gate_req;
    logic [`PERIPH_W+4:0] gate_en;

    assign in_sleep = (state == sleep_ctrl_pkg::ST_SLEEP);
    // Power-down and standby: I/O and converter clocks both stopped
    assign deep     = (state == sleep_ctrl_pkg::ST_SLEEP
                       || state == sleep_ctrl_pkg::ST_STARTUP)
                    && mode[1];

    // Domain requests per state and mode
    always_comb begin
        req_core    = !in_sleep;
        req_io      = !deep;
        req_conv    = !deep;
        req_osc     = 1'b1;
        periph_base = `PERIPH_ALL;
        if (in_sleep) begin
            case (mode)
                sleep_ctrl_pkg::MODE_IDLE: begin
                    periph_base = `PERIPH_ALL;
                end
                sleep_ctrl_pkg::MODE_NOISE: begin
                    req_io      = 1'b0;
                    periph_base = `NR_KEEP_MASK;
                end
                sleep_ctrl_pkg::MODE_PWR_DOWN: begin
                    req_osc     = osc_kept;
                    periph_base = `PERIPH_NONE;
                end
                default: begin
                    periph_base = `PERIPH_NONE;
                end
            endcase
        end else if (deep) begin
            periph_base = `PERIPH_NONE;
        end
        // Stopped bits only gate; peripheral state is simply frozen
        req_periph = periph_base & ~i_peripheral_clock_stop_bits;
    end

    assign gate_req = {req_core, req_core, req_io, req_conv, req_osc,
                       req_periph};

    // All enables registered together, so they change on one edge
    clock_gate_cell #(
        .W (`PERIPH_W + 5)
    ) u_gates (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_req     (gate_req),
        .o_en      (gate_en)
    );

    assign {o_core_clk_en, o_flash_clk_en, o_io_clk_en, o_conv_clk_en,
            o_osc_enable, o_periph_clk_en} = gate_en;

    // ======================================================================
    // Analog, fuse and pin controls
    // ======================================================================
    logic                 conv_prev;
    logic                 conv_ext;
    logic                 next_conv_ext;
    logic                 cmp_on;
    logic                 ref_on;
    logic [`PERIPH_W-1:0] blk;
    logic [`PERIPH_W-1:0] next_blk;
    logic                 bo_act;
    logic                 bo_smp;
    logic                 wd_run;
    logic [PIN_W-1:0]     buf_en;
    logic [PIN_W-1:0]     next_buf_en;

    // Comparator powers down in the deep modes or when disabled
    assign cmp_on = !i_comparator_disable && !deep;
    // Reference on while any user wants it, sleep or not
    assign ref_on = i_brownout_sleep_fuse | cmp_on | i_converter_enable
                  | (!i_comparator_disable
                     && i_comparator_uses_ref);

    // Control next values; a fresh re-enable beats a completion clear
    always_comb begin
        if (i_converter_enable && !conv_prev) begin
            next_conv_ext = 1'b1;
        end else if (i_conv_done) begin
            next_conv_ext = 1'b0;
        end else begin
            next_conv_ext = conv_ext;
        end
        next_blk    = i_peripheral_clock_stop_bits;
        next_buf_en = deep ? i_wake_pin_mask : {PIN_W{1'b1}};
        next_buf_en = next_buf_en & ~i_digital_input_disable_bits;
    end

    // Registered analog and pin controls
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            conv_prev <= 1'b0;
            conv_ext  <= 1'b0;
            blk       <= `PERIPH_NONE;
            bo_act    <= 1'b0;
            bo_smp    <= 1'b0;
            wd_run    <= 1'b0;
            buf_en    <= '1;
        end else begin
            conv_prev <= i_converter_enable;
            conv_ext  <= next_conv_ext;
            blk       <= next_blk;
            bo_act    <= i_brownout_sleep_fuse;
            bo_smp    <= i_brownout_sleep_fuse
                       & i_brownout_sampled_sel;
            wd_run    <= i_watchdog_enable;
            buf_en    <= next_buf_en;
        end
    end

    // ======================================================================
    // Output drive
    // ======================================================================
    assign o_sleeping            = in_sleep;
    assign o_core_hold           = (state != sleep_ctrl_pkg::ST_ACTIVE);
    assign o_resume              = resume;
    assign o_conv_start          = conv_start;
    assign o_conv_extended       = conv_ext;
    assign o_converter_power     = i_converter_enable;
    assign o_comparator_power    = cmp_on;
    assign o_reference_enable    = ref_on;
    assign o_brownout_active     = bo_act;
    assign o_brownout_sampled    = bo_smp;
    assign o_watchdog_run        = wd_run;
    assign o_periph_access_block = blk;
    assign o_input_buffer_en     = buf_en;

endmodule // sleep_clock_ctrl

/* pkg/sleep_ctrl_defines.svh */
// Purpose: Named constants for the sleep and clock gating controller
// Assumes: Included by bare name from the design files
// Notes:   Definitions only; the package holds the types
`ifndef SLEEP_CTRL_DEFINES_SVH
`define SLEEP_CTRL_DEFINES_SVH

// ==========================================================================
// Timing counts, in i_mclk cycles
// ==========================================================================
`define CNT_W               8
`define STANDBY_WAKE_CYCLES 8'h06
`define WAKE_HOLD_CYCLES    8'h04
`define OSC_STARTUP_DEFAULT 8'h10
`define CNT_ONE             8'h01
`define CNT_ZERO            8'h00

// ==========================================================================
// Peripheral clock-stop bit positions
// ==========================================================================
`define PERIPH_W     7
`define PSTOP_TWI    6
`define PSTOP_TIM1   5
`define PSTOP_TIM0   4
`define PSTOP_SERIAL 3
`define PSTOP_UART1  2
`define PSTOP_UART0  1
`define PSTOP_CONV   0
// Peripherals kept clocked in noise reduction: two-wire, both UARTs, conv
`define NR_KEEP_MASK 7'h47
`define PERIPH_ALL   7'h7f
`define PERIPH_NONE  7'h00

`endif

/* pkg/sleep_ctrl_pkg.sv */
// Purpose: Types for the sleep and clock gating controller
// Assumes: Used by scoped names only, never imported
// Notes:   Mode codes match the two-bit sleep mode select field
package sleep_ctrl_pkg;

    // ======================================================================
    // Sleep mode select encoding
    // ======================================================================
    typedef enum logic [1:0] {
        MODE_IDLE     = 2'h0,
        MODE_NOISE    = 2'h1,
        MODE_PWR_DOWN = 2'h2,
        MODE_STANDBY  = 2'h3
    } sleep_mode_t;

    // ======================================================================
    // Controller states
    // ======================================================================
    typedef enum logic [1:0] {
        ST_ACTIVE  = 2'h0,
        ST_SLEEP   = 2'h1,
        ST_STARTUP = 2'h2,
        ST_HOLD    = 2'h3
    } pm_state_t;

endpackage

/* hw/sync2.sv */
// Purpose: Two flip-flop synchroniser for asynchronous wake inputs
// Assumes: Inputs are levels held longer than two i_mclk periods
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps

module sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    // ======================================================================
    // Stage chain
    // ======================================================================
    // Next values
    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    // Registers only; cleared to no-wake on reset
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end

endmodule // sync2

/* hw/clock_gate_cell.sv */
// Purpose: Registered clock enable for a group of clock domains
// Assumes: Enables drive a gate that samples them on the clock edge
// Notes:   Enables open after reset so every domain runs at once
`timescale 1ns/1ps

module clock_gate_cell #(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_req,
    output logic      [W-1:0] o_en
);

    logic [W-1:0] next_en;

    // ======================================================================
    // Enable register
    // ======================================================================
    // Request taken whole; a change only lands on a clock edge
    always_comb begin
        next_en = i_req;
    end

    // Flip-flop output, so no partial pulse reaches a domain
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_en <= '1;
        end else begin
            o_en <= next_en;
        end
    end

endmodule // clock_gate_cell

/* dv/sleep_core_model.sv */
// Purpose: Core side model issuing sleep and holding a level wake
// Assumes: Requests arrive just after a clock edge
// Notes:   Wake level drops only once the core resumes
`timescale 1ns/1ps
module sleep_core_model (
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    input  wire logic i_go,
    input  wire logic i_wake_req,
    input  wire logic i_hold,
    input  wire logic i_resume,
    output logic      o_instr,
    output logic      o_wake
);
    // ======================================================
    // Sleep instruction and wake level
    // A short wake pulse could be lost while waking, so hold it
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_instr <= 1'h0;
            o_wake  <= 1'h0;
        end else begin
            o_instr <= i_go && !i_hold;  // One-cycle pulse
            o_wake  <= !i_resume && (o_wake || i_wake_req);
        end
    end
endmodule // sleep_core_model

/* dv/sleep_clock_ctrl_chk.sv */
// Purpose: Port timing checks for the sleep controller
// Assumes: Mode select held steady while asleep
// Notes:   Bound into every controller instance
`timescale 1ns/1ps
module sleep_clock_ctrl_chk (
    input wire logic       i_mclk,
    input wire logic       i_sys_rst,
    input wire logic       i_sleep_instr,
    input wire logic       i_sleep_enable_bit,
    input wire logic [1:0] i_sleep_mode_select,
    input wire logic       i_converter_enable,
    input wire logic       i_debug_link_enable_fuse,
    input wire logic       o_core_clk_en,
    input wire logic       o_io_clk_en,
    input wire logic       o_osc_enable,
    input wire logic       o_sleeping,
    input wire logic       o_core_hold,
    input wire logic       o_resume,
    input wire logic       o_conv_start,
    input wire logic       o_comparator_power
);
    // ======================================================
    // Sleep entry, gating and wake timing
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    a_sleep_taken: assert property (!o_core_hold && i_sleep_instr &&
        i_sleep_enable_bit |=> o_sleeping) else $error("sleep missed");
    a_sleep_refused: assert property (!o_core_hold && i_sleep_instr &&
        !i_sleep_enable_bit |=> !o_core_hold) else $error("sleep taken");
    a_idle_gating: assert property ($rose(o_sleeping) &&
        $past(i_sleep_mode_select) == 2'h0 |=> !o_core_clk_en && o_io_clk_en)
        else $error("idle gating wrong");
    a_deep_osc_off: assert property ($rose(o_sleeping) &&
        $past(i_sleep_mode_select) == 2'h2 && !i_debug_link_enable_fuse
        |=> !o_osc_enable) else $error("oscillator kept");
    a_conv_autostart: assert property ($rose(o_sleeping) &&
        !$past(i_sleep_mode_select[1]) && $past(i_converter_enable)
        |-> o_conv_start) else $error("no conversion start");
    a_comp_deep_off: assert property (o_sleeping &&
        i_sleep_mode_select[1] |-> !o_comparator_power) else $error("comp on");
    a_standby_wake: assert property ($fell(o_sleeping) &&
        i_sleep_mode_select == 2'h3 |-> ##7 o_io_clk_en ##3 o_resume)
        else $error("standby wake timing");
    a_idle_hold: assert property ($fell(o_sleeping) &&
        !i_sleep_mode_select[1] |-> o_core_hold[*4] ##1
        (o_resume && !o_core_hold)) else $error("hold length wrong");
    c_enter: cover property ($rose(o_sleeping));
    c_standby: cover property (o_resume && i_sleep_mode_select == 2'h3);
    c_conv: cover property (o_conv_start);
endmodule // sleep_clock_ctrl_chk
bind sleep_clock_ctrl sleep_clock_ctrl_chk chk_u (.*);

/* dv/tb_sleep_clock_ctrl.sv */
// Purpose: Self-checking bench for the sleep clock controller
// Assumes: Core model drives sleep requests and the level wake
// Notes:   Short start-up count keeps the run brief
`timescale 1ns/1ps
module tb_sleep_clock_ctrl;
    localparam logic [7:0] STARTUP = 8'h02;
    logic i_mclk = 1'h0, i_sys_rst = 1'h1, go = 1'h0, wake_req = 1'h0;
    logic i_sleep_enable_bit = 1'h0, i_converter_enable = 1'h1;
    logic i_comparator_disable = 1'h0, i_comparator_uses_ref = 1'h1;
    logic i_brownout_sleep_fuse = 1'h1, i_brownout_sampled_sel = 1'h1;
    logic i_watchdog_enable = 1'h1, i_debug_link_enable_fuse = 1'h0;
    logic i_periph_irq = 1'h0, i_conv_done = 1'h0, i_watchdog_irq = 1'h0;
    logic i_self_program_write_ready = 1'h0, i_pin_change_irq = 1'h0;
    logic i_universal_serial_unit_start = 1'h0, i_start_frame_detect = 1'h0;
    logic i_two_wire_slave_match = 1'h0, i_sleep_instr;
    logic i_external_level_interrupt, o_watchdog_run, o_conv_extended;
    logic [1:0] i_sleep_mode_select = 2'h0;
    logic [6:0] i_peripheral_clock_stop_bits = 7'h00, o_periph_clk_en;
    logic [6:0] o_periph_access_block;
    logic [17:0] i_digital_input_disable_bits = 18'h0_000f;
    logic [17:0] i_wake_pin_mask = 18'h0_0101, o_input_buffer_en;
    logic o_core_clk_en, o_flash_clk_en, o_io_clk_en, o_conv_clk_en;
    logic o_osc_enable, o_sleeping, o_core_hold, o_resume, o_conv_start;
    logic o_converter_power, o_comparator_power, o_reference_enable;
    logic o_brownout_active, o_brownout_sampled;
    int mismatches = 0, comparisons = 0, n;
    // ======================================================
    // Clock, core model and controller
    always #4 i_mclk = ~i_mclk;
    sleep_core_model core_u (.i_mclk, .i_sys_rst, .i_go(go),
        .i_wake_req(wake_req), .i_hold(o_core_hold), .i_resume(o_resume),
        .o_instr(i_sleep_instr), .o_wake(i_external_level_interrupt));
    sleep_clock_ctrl #(.PIN_W(18), .OSC_STARTUP(STARTUP)) dut_u (.*);
    // Shared steps, always settled 1 ns after the edge
    task automatic tick(input int k);
        repeat (k) @(posedge i_mclk);
        #1;
    endtask
    task automatic enter();
        go = 1'h1;
        tick(1);
        go = 1'h0;
        tick(1);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard: full run needs about 120 cycles
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
    // ======================================================
    // Test sequence
    initial begin
        tick(2);
        check({o_core_clk_en, o_core_hold, o_periph_clk_en}, 9'h17f);
        i_sys_rst = 1'h0;
        enter();
        check(o_core_hold, 1'h0);
        i_sleep_enable_bit = 1'h1;
        // Every mode, plus power-down with the debug fuse set
        for (int k = 0; k < 5; k++) begin
            i_sleep_mode_select = 2'(k == 4 ? 2 : k);
            i_debug_link_enable_fuse = (k == 4);
            enter();
            check(o_conv_start, k < 2);
            tick(2);
            check({o_io_clk_en, o_osc_enable, o_comparator_power},
                  {k == 0, k != 2, k < 2});
            check({o_watchdog_run, o_brownout_active, o_reference_enable,
                  o_brownout_sampled}, 4'hf);
            check({o_conv_clk_en, o_flash_clk_en}, {k < 2, 1'h0});
            check(o_input_buffer_en, k > 1 ? 18'h0_0100 : 18'h3_fff0);
            i_periph_irq = 1'h1;
            i_self_program_write_ready = k > 1;
            if (k != 0) begin
                tick(4);
                check(o_sleeping, 1'h1);
                i_periph_irq = 1'h0;
                wake_req = 1'h1;
            end
            for (n = 0; o_sleeping && n < 50; n++) tick(1);
            wake_req = 1'h0;
            for (n = 0; !o_resume && n < 50; n++) tick(1);
            check(n, k == 2 ? 4 + STARTUP : k > 2 ? 10 : 4);
            i_periph_irq = 1'h0;
            i_self_program_write_ready = 1'h0;
            tick(2); // Let the synced wake level drop
        end
        // Peripheral clock stop only while active
        i_peripheral_clock_stop_bits = 7'h15;
        tick(2);
        check({o_periph_clk_en, o_periph_access_block}, 14'h3515);
        i_peripheral_clock_stop_bits = 7'h00;
        tick(2);
        check({o_periph_clk_en, o_periph_access_block}, 14'h3f80);
        {i_converter_enable, i_comparator_disable, i_conv_done} = 3'h3;
        i_brownout_sleep_fuse = 1'h0;
        tick(2);
        check({o_reference_enable, o_converter_power}, 2'h0);
        {i_converter_enable, i_conv_done} = 2'h2;
        tick(2);
        check({o_reference_enable, o_conv_extended}, 2'h3);
        i_conv_done = 1'h1;
        tick(1);
        i_conv_done = 1'h0;
        check(o_conv_extended, 1'h0);
        // Reset in the middle of power-down
        enter();
        tick(2);
        i_sys_rst = 1'h1;
        tick(1);
        check({o_core_clk_en, o_core_hold, o_periph_clk_en}, 9'h17f);
        i_sys_rst = 1'h0;
        tick(2);
        print_verdict();
    end
endmodule // tb_sleep_clock_ctrl
